// *** design/system_clock_source_select.sv ***
// Summary of operation
// - Select code 11 drives the system clock straight from the direct clock input.
// - Select code 10 with bypass set takes the clock from crystal or internal source via the prescaler.
// - The prescaler factor is the divide field plus one and the output rate is the source rate over it.
// - A prescaler factor of one passes the source through with its own duty cycle.
// - The prescaler reaches a largest factor of 1024 for the slowest clock.
// - Crystal bypass with factor one gives the crystal clock one system cycle later than direct drive gives its input.
// - Everything inside is sequenced by sys_clk; the source clocks are only sampled as levels.
// - Select code 00 runs the system clock from the wakeup clock.
// - Select code 10 with bypass clear gives input rate times N over P times K2, each field plus one.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module system_clock_source_select
    import clock_select_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              direct_clock_input,
    input  wire logic              crystal_input,
    input  wire logic              internal_clock_input,
    input  wire logic              wakeup_clock_input,
    output logic                   system_clock_out,
    output logic                   clock_switch_pending
);

    css_state_s s_q;
    css_state_s s_d;

    logic              osc_level;
    logic              osc_rise;
    logic              commit;
    logic              k1_out;
    logic              ref_out;
    logic              ref_rise;
    logic              cand;
    logic [N_W:0]      n_factor;
    logic [K2_W:0]     k2_factor;
    logic [ACC_W-1:0]  step;
    logic [ACC_W-1:0]  modulus;
    logic [ACC_W-1:0]  acc_sum;
    logic [DATA_W-1:0] rd_word;
    logic [K1_W-1:0]   pll_input_divide_field_wide;

    // Oscillator path: crystal or internal source
    assign osc_level = s_q.act.osc_internal ? internal_clock_input
                                            : crystal_input;
    assign osc_rise  = osc_level & ~s_q.osc_prev;

    // New settings only take over while the output rests low
    assign commit    = s_q.pending & ~s_q.sysclk;

    assign pll_input_divide_field_wide = K1_W'(s_q.act.pll_input_divide_field);

    edge_divider u_prescaler (
        .sys_clk      (sys_clk),
        .nrst         (nrst),
        .clear        (commit),
        .src_level    (osc_level),
        .src_rise     (osc_rise),
        .divide_field (s_q.act.prescaler_divide_field),
        .div_out      (k1_out)
    );

    edge_divider u_ref_divider (
        .sys_clk      (sys_clk),
        .nrst         (nrst),
        .clear        (commit),
        .src_level    (osc_level),
        .src_rise     (osc_rise),
        .divide_field (pll_input_divide_field_wide),
        .div_out      (ref_out)
    );

    assign ref_rise  = ref_out & ~s_q.ref_prev;

    // Loop factors, each field plus one
    assign n_factor  = {1'b0, s_q.act.pll_multiply_field} + 1'b1;
    assign k2_factor = {1'b0, s_q.act.pll_output_divide_field} + 1'b1;
    // Two toggles per output period, so the step is twice N
    assign step      = ACC_W'({n_factor, 1'b0});
    assign modulus   = ACC_W'(s_q.per) * ACC_W'(k2_factor);
    assign acc_sum   = s_q.acc + step;

    // Candidate clock for the active mode
    always_comb begin
        cand = 1'b0;
        unique case (s_q.act.clock_source_select)
            SRC_WAKEUP: begin
                cand = wakeup_clock_input;
            end
            SRC_PLL: begin
                if (s_q.act.vco_bypass_bit) begin
                    // Crystal with factor one lags direct drive by the prescaler register stage
                    cand = k1_out;
                end else begin
                    cand = s_q.pll_level;
                end
            end
            SRC_DIRECT: begin
                cand = direct_clock_input;
            end
            SRC_RESERVED: begin
                // Reserved code parks the clock low
                cand = 1'b0;
            end
        endcase
    end

    // Register readback: shadow copies of the control registers, then status
    always_comb begin
        rd_word = '0;
        unique case (reg_addr)
            OFS_SYSTEM_CONTROL: begin
                rd_word[SYS_SEL_LSB +: SEL_W] = s_q.cfg.clock_source_select;
                rd_word[SYS_OSC_INT_BIT]      = s_q.cfg.osc_internal;
            end
            OFS_PLL_CONTROL: begin
                rd_word[PLL_BYPASS_BIT] = s_q.cfg.vco_bypass_bit;
                rd_word[PLL_PLL_INPUT_DIVIDE_FIELD_LSB +: P_W] =
                    s_q.cfg.pll_input_divide_field;
                rd_word[PLL_PLL_MULTIPLY_FIELD_LSB +: N_W] = s_q.cfg.pll_multiply_field;
                rd_word[PLL_K2_LSB +: K2_W]  =
                    s_q.cfg.pll_output_divide_field;
            end
            OFS_PRESCALER: begin
                rd_word[PRE_K1_LSB +: K1_W] =
                    s_q.cfg.prescaler_divide_field;
            end
            OFS_STATUS: begin
                rd_word[STS_SEL_LSB +: SEL_W] = s_q.act.clock_source_select;
                rd_word[STS_BYPASS_BIT]       = s_q.act.vco_bypass_bit;
                rd_word[STS_PEND_BIT]         = s_q.pending;
                rd_word[STS_CLK_BIT]          = s_q.sysclk;
                rd_word[STS_OSC_INT_BIT]      = s_q.act.osc_internal;
                rd_word[STS_PER_LSB +: PER_W] = s_q.per;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    always_comb begin
        s_d          = s_q;
        s_d.osc_prev = osc_level;
        s_d.ref_prev = ref_out;

        // Control register writes land in the shadow copy and mark a switch
        if (reg_write) begin
            unique case (reg_addr)
                OFS_SYSTEM_CONTROL: begin
                    s_d.cfg.clock_source_select =
                        reg_wdata[SYS_SEL_LSB +: SEL_W];
                    s_d.cfg.osc_internal = reg_wdata[SYS_OSC_INT_BIT];
                    s_d.pending          = 1'b1;
                end
                OFS_PLL_CONTROL: begin
                    s_d.cfg.vco_bypass_bit = reg_wdata[PLL_BYPASS_BIT];
                    s_d.cfg.pll_input_divide_field =
                        reg_wdata[PLL_PLL_INPUT_DIVIDE_FIELD_LSB +: P_W];
                    s_d.cfg.pll_multiply_field =
                        reg_wdata[PLL_PLL_MULTIPLY_FIELD_LSB +: N_W];
                    s_d.cfg.pll_output_divide_field =
                        reg_wdata[PLL_K2_LSB +: K2_W];
                    s_d.pending = 1'b1;
                end
                OFS_PRESCALER: begin
                    s_d.cfg.prescaler_divide_field =
                        reg_wdata[PRE_K1_LSB +: K1_W];
                    s_d.pending = 1'b1;
                end
                default: begin
                    s_d.pending = s_q.pending;
                end
            endcase
        end

        // Reference period in system cycles, after the input divider
        if (s_q.per_cnt != '1) begin
            s_d.per_cnt = s_q.per_cnt + 1'b1;
        end
        if (ref_rise) begin
            s_d.per     = s_q.per_cnt + 1'b1;
            s_d.per_cnt = '0;
        end

        // Loop model: phase accumulator locked to the reference period
        if (s_q.per == '0) begin
            s_d.acc       = '0;
            s_d.pll_level = 1'b0;
        end else if (acc_sum >= modulus) begin
            // Slips gradually on a period change, no abrupt jump
            s_d.acc       = acc_sum - modulus;
            s_d.pll_level = ~s_q.pll_level;
        end else begin
            s_d.acc = acc_sum;
        end

        // Output stage: a high phase always runs to its natural end
        if (commit) begin
            s_d.act      = s_q.cfg;
            s_d.wait_low = 1'b1;
            s_d.sysclk   = 1'b0;
            s_d.acc      = '0;
            s_d.pll_level = 1'b0;
            // A control register write in this very cycle keeps the switch pending
            s_d.pending  = reg_write & (reg_addr != OFS_STATUS) &
                           (reg_addr <= OFS_PRESCALER);
        end else if (s_q.wait_low) begin
            // Join the new source only from a low phase, no runt high
            s_d.sysclk = 1'b0;
            if (!cand) begin
                s_d.wait_low = 1'b0;
            end
        end else if (s_q.pending && !cand) begin
            // Hold low for the commit on the next cycle
            s_d.sysclk = 1'b0;
        end else begin
            s_d.sysclk = cand;
        end

        // Read data stands only in the cycle after the strobe
        s_d.rdata = reg_read ? rd_word : '0;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q          <= '0;
            s_q.cfg      <= RST_CFG;
            s_q.act      <= RST_CFG;
        end else begin
            s_q <= s_d;
        end
    end

    assign system_clock_out     = s_q.sysclk;
    assign clock_switch_pending = s_q.pending;
    assign reg_rdata            = s_q.rdata;

endmodule

// *** design/clock_select_pkg.sv ***
package clock_select_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Field widths
    localparam int SEL_W  = 2;
    localparam int P_W    = 4;
    localparam int N_W    = 7;
    localparam int K2_W   = 7;
    localparam int K1_W   = 10;
    localparam int PER_W  = 16;
    localparam int ACC_W  = 24;

    // Clock source select codes
    localparam logic [SEL_W-1:0] SRC_WAKEUP   = 2'h0;
    localparam logic [SEL_W-1:0] SRC_RESERVED = 2'h1;
    localparam logic [SEL_W-1:0] SRC_PLL      = 2'h2;
    localparam logic [SEL_W-1:0] SRC_DIRECT   = 2'h3;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_SYSTEM_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PLL_CONTROL    = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_PRESCALER      = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_STATUS         = 4'h3;

    // Field positions
    localparam int SYS_SEL_LSB     = 0;
    localparam int SYS_OSC_INT_BIT = 2;
    localparam int PLL_BYPASS_BIT  = 0;
    localparam int PLL_PLL_INPUT_DIVIDE_FIELD_LSB    = 4;
    localparam int PLL_PLL_MULTIPLY_FIELD_LSB    = 8;
    localparam int PLL_K2_LSB      = 16;
    localparam int PRE_K1_LSB      = 0;
    localparam int STS_SEL_LSB     = 0;
    localparam int STS_BYPASS_BIT  = 2;
    localparam int STS_PEND_BIT    = 3;
    localparam int STS_CLK_BIT     = 4;
    localparam int STS_OSC_INT_BIT = 5;
    localparam int STS_PER_LSB     = 16;

    // Reset values
    localparam logic [SEL_W-1:0] RST_SEL     = SRC_WAKEUP;
    localparam logic             RST_BYPASS  = 1'b1;
    localparam logic             RST_OSC_INT = 1'b0;
    localparam logic [P_W-1:0]   RST_PLL_INPUT_DIVIDE_FIELD    = 4'h0;
    localparam logic [N_W-1:0]   RST_PLL_MULTIPLY_FIELD    = 7'h00;
    localparam logic [K2_W-1:0]  RST_PLL_OUTPUT_DIVIDE_FIELD   = 7'h00;
    localparam logic [K1_W-1:0]  RST_PRESCALER_DIVIDE_FIELD   = 10'h000;

    typedef struct packed {
        logic [SEL_W-1:0] clock_source_select;
        logic             vco_bypass_bit;
        logic             osc_internal;
        logic [P_W-1:0]   pll_input_divide_field;
        logic [N_W-1:0]   pll_multiply_field;
        logic [K2_W-1:0]  pll_output_divide_field;
        logic [K1_W-1:0]  prescaler_divide_field;
    } clk_cfg_s;

    localparam clk_cfg_s RST_CFG = '{
        clock_source_select     : RST_SEL,
        vco_bypass_bit          : RST_BYPASS,
        osc_internal            : RST_OSC_INT,
        pll_input_divide_field  : RST_PLL_INPUT_DIVIDE_FIELD,
        pll_multiply_field      : RST_PLL_MULTIPLY_FIELD,
        pll_output_divide_field : RST_PLL_OUTPUT_DIVIDE_FIELD,
        prescaler_divide_field  : RST_PRESCALER_DIVIDE_FIELD
    };

    typedef struct packed {
        logic [K1_W-1:0] cnt;
        logic            level;
    } div_state_s;

    typedef struct packed {
        clk_cfg_s          cfg;
        clk_cfg_s          act;
        logic              pending;
        logic              wait_low;
        logic              sysclk;
        logic              osc_prev;
        logic              ref_prev;
        logic [PER_W-1:0]  per_cnt;
        logic [PER_W-1:0]  per;
        logic [ACC_W-1:0]  acc;
        logic              pll_level;
        logic [DATA_W-1:0] rdata;
    } css_state_s;

endpackage

// *** design/edge_divider.sv ***
`timescale 1ns/1ps

module edge_divider
    import clock_select_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            nrst,
    input  wire logic            clear,
    input  wire logic            src_level,
    input  wire logic            src_rise,
    input  wire logic [K1_W-1:0] divide_field,
    output logic                 div_out
);

    div_state_s s_q;
    div_state_s s_d;
    logic [K1_W-1:0] cnt_next;

    always_comb begin
        s_d      = s_q;
        cnt_next = s_q.cnt;
        if (clear) begin
            s_d.cnt   = '0;
            s_d.level = 1'b0;
        end else if (divide_field == '0) begin
            // Factor one: source passes through, duty cycle kept
            s_d.cnt   = '0;
            s_d.level = src_level;
        end else if (src_rise) begin
            // Factor is field plus one, counted on source edges
            if (s_q.cnt == divide_field) begin
                cnt_next = '0;
            end else begin
                cnt_next = s_q.cnt + 1'b1;
            end
            s_d.cnt   = cnt_next;
            s_d.level = (cnt_next <= (divide_field >> 1));
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign div_out = s_q.level;

endmodule

// *** verif/clock_select_props.sv ***
`timescale 1ns/1ps

module clock_select_props
    import clock_select_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              direct_clock_input,
    input wire logic              crystal_input,
    input wire logic              internal_clock_input,
    input wire logic              wakeup_clock_input,
    input wire logic              system_clock_out,
    input wire logic              clock_switch_pending
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence status_read;
        reg_read && reg_addr == OFS_STATUS;
    endsequence

    sequence ctrl_write;
        reg_write && reg_addr <= OFS_PRESCALER;
    endsequence

    // Commit cycle: pending, output low, no fresh write to re-arm
    sequence commit_cycle;
        clock_switch_pending && !system_clock_out && !reg_write;
    endsequence

    rdata_idle_a: assert property (
        !$past(reg_read) |-> reg_rdata == '0)
        else $error("read data not zero outside read answer");
    unmapped_read_a: assert property (
        reg_read && reg_addr > OFS_STATUS |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    pend_arm_a: assert property (
        ctrl_write |=> clock_switch_pending)
        else $error("control write did not arm pending");
    status_ro_a: assert property (
        reg_write && reg_addr == OFS_STATUS && !clock_switch_pending
        |=> !clock_switch_pending)
        else $error("status write armed pending");
    switch_commit_a: assert property (
        commit_cycle |=> !clock_switch_pending)
        else $error("switch not committed while output low");
    no_runt_a: assert property (
        clock_switch_pending |=> !$rose(system_clock_out))
        else $error("new high pulse while switch pending");
    pend_status_a: assert property (
        status_read |=> reg_rdata[STS_PEND_BIT] == $past(clock_switch_pending))
        else $error("status pending bit wrong");
    level_status_a: assert property (
        status_read |=> reg_rdata[STS_CLK_BIT] == $past(system_clock_out))
        else $error("status clock level bit wrong");
endmodule

bind system_clock_source_select clock_select_props u_clock_select_props (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .direct_clock_input(direct_clock_input),
    .crystal_input(crystal_input),
    .internal_clock_input(internal_clock_input),
    .wakeup_clock_input(wakeup_clock_input),
    .system_clock_out(system_clock_out),
    .clock_switch_pending(clock_switch_pending)
);

// *** verif/system_clock_source_select_tb_top.sv ***
`timescale 1ns/1ps

module system_clock_source_select_tb_top;
    import clock_select_pkg::*;
    logic              sys_clk   = 1'b0;
    logic              nrst      = 1'b0;
    logic [ADDR_W-1:0] reg_addr  = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_write = 1'b0;
    logic              reg_read  = 1'b0;
    logic [7:0]        cnt       = 8'h00;
    logic [DATA_W-1:0] reg_rdata;
    logic              system_clock_out;
    logic              clock_switch_pending;
    logic [3:0]        src;
    logic [DATA_W-1:0] rd;
    int                fails     = 0;
    int                checked   = 0;
    int                n;

    // Sources: wakeup /32, direct /4, crystal /8, internal /16
    assign src = {cnt[3], cnt[2], cnt[1], cnt[4]};

    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cnt <= cnt + 8'h01;

    system_clock_source_select u_system_clock_source_select (
        .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .direct_clock_input(cnt[1]), .crystal_input(cnt[2]),
        .internal_clock_input(cnt[3]), .wakeup_clock_input(cnt[4]),
        .system_clock_out(system_clock_out),
        .clock_switch_pending(clock_switch_pending)
    );

    task automatic check(input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a,
                          output logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Several writes on purpose: each one re-arms the pending switch
    task automatic setup(input logic [DATA_W-1:0] sys, pll, pre);
        int k;
        wr(OFS_PRESCALER, pre);
        wr(OFS_PLL_CONTROL, pll);
        wr(OFS_SYSTEM_CONTROL, sys);
        k = 0;
        @(negedge sys_clk);
        // A slow prescaler holds the switch through its long high phase
        while (clock_switch_pending !== 1'b0 && k < 10000) begin
            @(negedge sys_clk);
            k++;
        end
        check(clock_switch_pending, 1'b0);
        repeat (100) @(posedge sys_clk);
    endtask

    // Output must trail the source by lag cycles, one or two
    task automatic follow(input int idx, input int len, input int lag);
        logic [1:0] hist;
        hist = 2'b00;
        repeat (lag) begin
            @(negedge sys_clk);
            hist = {hist[0], src[idx]};
        end
        repeat (len) begin
            @(negedge sys_clk);
            check(system_clock_out, hist[lag-1]);
            hist = {hist[0], src[idx]};
        end
    endtask

    // Cycles between two rising edges of the output
    task automatic gap_of(output int g);
        logic last;
        int   r;
        int   k;
        last = 1'b1;
        r = 0;
        k = 0;
        g = 0;
        while (r < 2 && k < 20000) begin
            @(negedge sys_clk);
            k++;
            if (r == 1) g++;
            if (last === 1'b0 && system_clock_out === 1'b1) r++;
            last = system_clock_out;
        end
    endtask

    task automatic rises(input int len, output int c);
        logic last;
        last = 1'b1;
        c = 0;
        repeat (len) begin
            @(negedge sys_clk);
            if (last === 1'b0 && system_clock_out === 1'b1) c++;
            last = system_clock_out;
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge sys_clk);
        fails++;
        summarize;
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        rd_reg(OFS_STATUS, rd);
        check(rd[3:0], 4'h4);
        rd_reg(OFS_PLL_CONTROL, rd);
        check(rd, 32'h0000_0001);
        rd_reg(4'h7, rd);
        check(rd, '0);
        wr(OFS_STATUS, 32'h0000_0003);
        rd_reg(OFS_STATUS, rd);
        check(rd[3:0], 4'h4);
        follow(0, 64, 1);
        setup(32'h0000_0003, 32'h0000_0001, 32'h0000_0000);
        follow(1, 64, 1);
        rd_reg(OFS_STATUS, rd);
        check(rd[3:0], 4'h7);
        setup(32'h0000_0002, 32'h0000_0001, 32'h0000_0000);
        // Prescaler path adds its own register stage before the output
        follow(2, 64, 2);
        setup(32'h0000_0006, 32'h0000_0001, 32'h0000_0000);
        follow(3, 64, 2);
        setup(32'h0000_0002, 32'h0000_0001, 32'h0000_0002);
        gap_of(n);
        check(n, 32'h0000_0018);
        rd_reg(OFS_PRESCALER, rd);
        check(rd, 32'h0000_0002);
        setup(32'h0000_0002, 32'h0000_0001, 32'h0000_03ff);
        gap_of(n);
        check(n, 32'h0000_2000);
        setup(32'h0000_0001, 32'h0000_0001, 32'h0000_0000);
        rises(200, n);
        check(n, 32'h0000_0000);
        setup(32'h0000_0002, 32'h0001_0300, 32'h0000_0000);
        rises(400, n);
        check(n >= 96 && n <= 104, 1'b1);
        summarize;
    end
endmodule
